//--- verilog/junction_pkg.sv
// shared types and constants for the junction route signal logic
// assumes one clock domain and active-low occupancy wires throughout
package junction_pkg;

  // ****************************************
  // wire levels and route codes
  // ****************************************
  localparam logic ACTIVE_N = 1'b0;
  localparam logic IDLE_N = 1'b1;
  localparam logic ROUTE_MAIN = 1'b0;
  localparam logic ROUTE_DIV = 1'b1;
  localparam logic AD_LOW = 1'b0;
  localparam logic AD_HIGH = 1'b1;
  localparam int SYNC_STAGES = 2;

  // ****************************************
  // aspects and bus bundles
  // ****************************************
  typedef enum logic [1:0] {
    ASPECT_STOP = 2'b00,
    ASPECT_APPROACH = 2'b01,
    ASPECT_CLEAR = 2'b10
  } aspect_e;

  // wires arriving on one end of the node
  typedef struct packed {
    logic approach_n;
    logic adv_approach_n;
    logic ad;
  } end_in_s;

  // wires leaving one end of the node
  typedef struct packed {
    logic approach_out_n;
    logic adv_approach_out_n;
    logic ad;
  } end_out_s;

  // synchroniser bundle: turnout, three detectors, three ends
  localparam int SYNC_W = 13;
  localparam logic [SYNC_W-1:0] SYNC_RST = 13'h0fb6;
  localparam end_out_s END_OUT_IDLE = '{IDLE_N, IDLE_N, AD_LOW};

endpackage

//--- verilog/sync_bank.sv
// bank of two-stage synchronisers, one per bit
// assumes inputs are slow levels; clock enable freezes both stages
`timescale 1ns/100ps
`default_nettype none
module sync_bank #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] din,
  output var logic [WIDTH-1:0] dout
);

  // ****************************************
  // per-bit flop pairs
  // ****************************************
  // stage one feeds only stage two, never any logic
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta;
      always_ff @(posedge clk) begin
        if (srst) begin
          meta <= RST_VAL[i];
          dout[i] <= RST_VAL[i];
        end else if (ce) begin
          meta <= din[i];
          dout[i] <= meta;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

//--- verilog/junction_route_signal_logic.sv
// junction node: trunk splits into main and diverging routes
// assumes srst and ce are levels on clk, other inputs slow levels; outputs are registered
//
// How it works
// - ad high only when diverging, no trains
// - ad leaves on the trunk end only
// - received ad is terminated, never forwarded
// - ad from both directions shown separately
// - diverging forces trunk approach out low
// - branch approach outs never get that force
// - branch block occupied forces ad low
// - turnout picks which branch joins trunk
// - only one branch joined at any time
// - unselected branch signal forced to stop
// - diverging: upper stop, lower clear if free
// - occupancy is active low wired-or
`timescale 1ns/100ps
`default_nettype none
module junction_route_signal_logic (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic turnout_div,
  input wire logic trunk_occ_n,
  input wire logic main_occ_n,
  input wire logic div_occ_n,
  input wire junction_pkg::end_in_s trunk_in,
  input wire junction_pkg::end_in_s main_in,
  input wire junction_pkg::end_in_s div_in,
  output junction_pkg::end_out_s trunk_out,
  output junction_pkg::end_out_s main_out,
  output junction_pkg::end_out_s div_out,
  output junction_pkg::aspect_e head_upper,
  output junction_pkg::aspect_e head_lower,
  output junction_pkg::aspect_e main_head,
  output junction_pkg::aspect_e div_head,
  output var logic ad_seen_trunk,
  output var logic ad_seen_branch
);
  import junction_pkg::*;

  // ****************************************
  // input synchronisation
  // ****************************************
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] synced;
  logic s_turn;
  logic s_trunk_occ_n;
  logic s_main_occ_n;
  logic s_div_occ_n;
  end_in_s s_trunk_in;
  end_in_s s_main_in;
  end_in_s s_div_in;

  assign raw = {turnout_div, trunk_occ_n, main_occ_n, div_occ_n,
                trunk_in, main_in, div_in};

  // turnout and detectors are asynchronous to clk
  sync_bank #(
    .WIDTH(SYNC_W),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .din(raw),
    .dout(synced)
  );

  assign {s_turn, s_trunk_occ_n, s_main_occ_n, s_div_occ_n,
          s_trunk_in, s_main_in, s_div_in} = synced;

  // ****************************************
  // route selection
  // ****************************************
  logic sel_div;
  logic sel_occ_n;
  logic all_clear;
  end_in_s sel_in;

  assign sel_div = (s_turn == ROUTE_DIV);
  // one mux select: the trunk can never join both branches
  assign sel_occ_n = sel_div ? s_div_occ_n : s_main_occ_n;
  assign sel_in = sel_div ? s_div_in : s_main_in;
  // detectors are wired-or, released means idle
  assign all_clear = (s_trunk_occ_n == IDLE_N) &&
                     (s_main_occ_n == IDLE_N) &&
                     (s_div_occ_n == IDLE_N);

  // ****************************************
  // bus outputs
  // ****************************************
  end_out_s next_trunk_out;
  end_out_s next_main_out;
  end_out_s next_div_out;
  end_out_s joined_out;

  // pretend occupied so a plain display node still warns
  assign next_trunk_out.approach_out_n =
    sel_div ? ACTIVE_N : sel_occ_n;
  assign next_trunk_out.adv_approach_out_n = sel_in.approach_n;
  assign next_trunk_out.ad =
    (sel_div && all_clear) ? AD_HIGH : AD_LOW;

  // branch side sees the trunk only when joined, never forced
  assign joined_out.approach_out_n = s_trunk_occ_n;
  assign joined_out.adv_approach_out_n = s_trunk_in.approach_n;
  assign joined_out.ad = AD_LOW;
  assign next_main_out = sel_div ? END_OUT_IDLE : joined_out;
  assign next_div_out = sel_div ? joined_out : END_OUT_IDLE;

  // ****************************************
  // signal heads
  // ****************************************
  function automatic aspect_e pick(input logic forced, input logic occ_n,
                                   input logic appr_n);
    aspect_e a;
    a = ASPECT_CLEAR;
    if (forced || occ_n == ACTIVE_N) begin
      a = ASPECT_STOP;
    end else if (appr_n == ACTIVE_N) begin
      a = ASPECT_APPROACH;
    end
    return a;
  endfunction

  aspect_e next_upper;
  aspect_e next_lower;
  aspect_e next_main_head;
  aspect_e next_div_head;

  assign next_upper =
    pick(sel_div, s_main_occ_n, s_main_in.approach_n);
  // lower head never shows approach, only clear when free
  assign next_lower = pick(!sel_div, s_div_occ_n, IDLE_N);
  assign next_main_head =
    pick(sel_div, s_trunk_occ_n, s_trunk_in.approach_n);
  assign next_div_head =
    pick(!sel_div, s_trunk_occ_n, s_trunk_in.approach_n);

  // ****************************************
  // output registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      trunk_out <= END_OUT_IDLE;
      main_out <= END_OUT_IDLE;
      div_out <= END_OUT_IDLE;
    end else if (ce) begin
      trunk_out <= next_trunk_out;
      main_out <= next_main_out;
      div_out <= next_div_out;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      head_upper <= ASPECT_STOP;
      head_lower <= ASPECT_STOP;
      main_head <= ASPECT_STOP;
      div_head <= ASPECT_STOP;
    end else if (ce) begin
      head_upper <= next_upper;
      head_lower <= next_lower;
      main_head <= next_main_head;
      div_head <= next_div_head;
    end
  end

  // terminated here: each direction gets its own indication
  always_ff @(posedge clk) begin
    if (srst) begin
      ad_seen_trunk <= AD_LOW;
      ad_seen_branch <= AD_LOW;
    end else if (ce) begin
      ad_seen_trunk <= s_trunk_in.ad;
      ad_seen_branch <= sel_in.ad;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_div_held;
    (ce && turnout_div && !srst) [*3];
  endsequence

  sequence s_branch_busy;
    ce && (s_main_occ_n == ACTIVE_N || s_div_occ_n == ACTIVE_N);
  endsequence

  property p_ad_high;
    @(posedge clk) disable iff (srst)
      ce |=> (trunk_out.ad == ($past(sel_div) && $past(all_clear)));
  endproperty
  a_ad_high: assert property (p_ad_high)
    else $error("trunk ad does not match route and detectors");

  property p_ad_low_busy;
    @(posedge clk) disable iff (srst)
      s_branch_busy |=> (trunk_out.ad == AD_LOW);
  endproperty
  a_ad_low_busy: assert property (p_ad_low_busy)
    else $error("trunk ad high while a branch block is occupied");

  property p_ad_one_way;
    @(posedge clk) disable iff (srst)
      (main_out.ad == AD_LOW) && (div_out.ad == AD_LOW);
  endproperty
  a_ad_one_way: assert property (p_ad_one_way)
    else $error("ad driven out of a branch end");

  property p_no_forward;
    @(posedge clk) disable iff (srst)
      ce && s_trunk_in.ad && !sel_div |=>
        (trunk_out.ad == AD_LOW) && ad_seen_trunk;
  endproperty
  a_no_forward: assert property (p_no_forward)
    else $error("received ad leaked onward or was not shown");

  property p_ad_seen;
    @(posedge clk) disable iff (srst)
      ce |=> (ad_seen_branch ==
        ($past(sel_div) ? $past(s_div_in.ad) : $past(s_main_in.ad)));
  endproperty
  a_ad_seen: assert property (p_ad_seen)
    else $error("branch ad indication wrong");

  property p_trunk_forced;
    @(posedge clk) disable iff (srst)
      s_div_held |=> (trunk_out.approach_out_n == ACTIVE_N);
  endproperty
  a_trunk_forced: assert property (p_trunk_forced)
    else $error("trunk approach out not forced on diverging");

  property p_branch_unforced;
    @(posedge clk) disable iff (srst)
      ce && sel_div && s_trunk_occ_n == IDLE_N |=>
        (div_out.approach_out_n == IDLE_N) &&
        (main_out.approach_out_n == IDLE_N);
  endproperty
  a_branch_unforced: assert property (p_branch_unforced)
    else $error("branch approach out forced by diverging setting");

  property p_route_main;
    @(posedge clk) disable iff (srst)
      ce && !sel_div |=>
        (main_out.approach_out_n == $past(s_trunk_occ_n)) &&
        (trunk_out.approach_out_n == $past(s_main_occ_n));
  endproperty
  a_route_main: assert property (p_route_main)
    else $error("main route not joined to trunk");

  property p_one_route;
    @(posedge clk) disable iff (srst)
      (main_out == END_OUT_IDLE) || (div_out == END_OUT_IDLE);
  endproperty
  a_one_route: assert property (p_one_route)
    else $error("both branches joined at once");

  property p_inactive_stop;
    @(posedge clk) disable iff (srst)
      ce |=> (($past(sel_div) ? main_head : div_head) == ASPECT_STOP);
  endproperty
  a_inactive_stop: assert property (p_inactive_stop)
    else $error("unselected branch signal not at stop");

  property p_div_heads;
    @(posedge clk) disable iff (srst)
      ce && sel_div && s_div_occ_n == IDLE_N |=>
        (head_upper == ASPECT_STOP) && (head_lower == ASPECT_CLEAR);
  endproperty
  a_div_heads: assert property (p_div_heads)
    else $error("double head wrong for diverging route");

  property p_sync_latency;
    @(posedge clk) disable iff (srst)
      (ce && !srst && !turnout_div) [*3] |=>
        (trunk_out.ad == AD_LOW) && (head_lower == ASPECT_STOP);
  endproperty
  a_sync_latency: assert property (p_sync_latency)
    else $error("main setting not seen after three enabled cycles");

endmodule
`default_nettype wire

//--- test/far_nodes.sv
// far-side model: neighbouring nodes and the display node
// assumes the bench commands approach and ad levels for each end
`timescale 1ns/100ps
`default_nettype none
module far_nodes (
  input wire logic clk,
  input wire logic [2:0] appr_n,
  input wire logic [2:0] ad_cmd,
  input wire junction_pkg::end_out_s trunk_out,
  output var junction_pkg::end_in_s trunk_in,
  output var junction_pkg::end_in_s main_in,
  output var junction_pkg::end_in_s div_in,
  output var junction_pkg::aspect_e disp_upper,
  output var junction_pkg::aspect_e disp_lower
);
  import junction_pkg::*;

  // ****************************************
  // wires toward the junction
  // ****************************************
  // advance approach left released, so the pull-up reads idle
  // crossovers pass ad straight through, never swapped
  assign trunk_in = '{appr_n[0], IDLE_N, ad_cmd[0]};
  assign main_in = '{appr_n[1], IDLE_N, ad_cmd[1]};
  assign div_in = '{appr_n[2], IDLE_N, ad_cmd[2]};

  // ****************************************
  // display node double head
  // ****************************************
  always_ff @(posedge clk) begin
    disp_upper <= (trunk_out.approach_out_n == ACTIVE_N) ?
      ASPECT_APPROACH : ASPECT_CLEAR;
    disp_lower <= (trunk_out.ad == AD_HIGH) ?
      ASPECT_APPROACH : ASPECT_STOP;
  end
endmodule
`default_nettype wire

//--- test/junction_route_signal_logic_tb_top.sv
// bench for the junction node: one scenario task per behaviour
// assumes 3 enabled edges from input to output
`timescale 1ns/100ps
`default_nettype none
module junction_route_signal_logic_tb_top;
  import junction_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic turnout_div = 1'b0;
  logic trunk_occ_n = 1'b1;
  logic main_occ_n = 1'b1;
  logic div_occ_n = 1'b1;
  logic [2:0] appr_n = 3'h7;
  logic [2:0] ad_cmd = 3'h0;
  end_in_s trunk_in, main_in, div_in;
  end_out_s trunk_out, main_out, div_out;
  aspect_e head_upper, head_lower, main_head, div_head, du, dl;
  logic ad_seen_trunk, ad_seen_branch;
  int fail_count = 0;
  int compares = 0;

  junction_route_signal_logic junction_route_signal_logic_i (
    .clk(clk), .srst(srst), .ce(ce), .turnout_div(turnout_div),
    .trunk_occ_n(trunk_occ_n), .main_occ_n(main_occ_n),
    .div_occ_n(div_occ_n), .trunk_in(trunk_in), .main_in(main_in),
    .div_in(div_in), .trunk_out(trunk_out), .main_out(main_out),
    .div_out(div_out), .head_upper(head_upper), .head_lower(head_lower),
    .main_head(main_head), .div_head(div_head),
    .ad_seen_trunk(ad_seen_trunk), .ad_seen_branch(ad_seen_branch));
  far_nodes far_nodes_i (
    .clk(clk), .appr_n(appr_n), .ad_cmd(ad_cmd), .trunk_out(trunk_out),
    .trunk_in(trunk_in), .main_in(main_in), .div_in(div_in),
    .disp_upper(du), .disp_lower(dl));

  initial begin
    forever #4 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  function automatic logic [2:0] a3(input aspect_e a);
    return {1'b0, a};
  endfunction

  task automatic chk(input string nm, input logic [2:0] seen,
                     input logic [2:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // slow levels: 4 edges covers sync plus output register
  task automatic drive(input logic td, t, m, d, input logic [2:0] ap, ad);
    @(posedge clk);
    turnout_div <= td;
    trunk_occ_n <= t;
    main_occ_n <= m;
    div_occ_n <= d;
    appr_n <= ap;
    ad_cmd <= ad;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic end_of_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // reset seen on three edges at start; release lands on an edge
  task automatic t_reset;
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk("trunk_out", trunk_out, 3'h6);
    chk("main_out", main_out, 3'h6);
    chk("div_out", div_out, 3'h6);
    chk("head_upper", a3(head_upper), a3(ASPECT_STOP));
    chk("head_lower", a3(head_lower), a3(ASPECT_STOP));
    chk("main_head", a3(main_head), a3(ASPECT_STOP));
    chk("div_head", a3(div_head), a3(ASPECT_STOP));
    chk("ad_seen", {1'b0, ad_seen_trunk, ad_seen_branch}, 3'h0);
    $display("test reset done");
  endtask

  task automatic t_main;
    drive(ROUTE_MAIN, 1'h1, 1'h1, 1'h1, 3'h4, 3'h0);
    chk("trunk_out", trunk_out, 3'h4);
    chk("main_out", main_out, 3'h4);
    chk("div_out", div_out, 3'h6);
    chk("head_upper", a3(head_upper), a3(ASPECT_APPROACH));
    chk("head_lower", a3(head_lower), a3(ASPECT_STOP));
    chk("main_head", a3(main_head), a3(ASPECT_APPROACH));
    chk("div_head", a3(div_head), a3(ASPECT_STOP));
    $display("test main done");
  endtask

  task automatic t_div;
    drive(ROUTE_DIV, 1'h1, 1'h1, 1'h1, 3'h6, 3'h0);
    chk("trunk_out", trunk_out, 3'h3);
    chk("trunk_ad", {2'h0, trunk_out.ad}, 3'h1);
    chk("main_out", main_out, 3'h6);
    chk("div_out", div_out, 3'h4);
    chk("head_upper", a3(head_upper), a3(ASPECT_STOP));
    chk("head_lower", a3(head_lower), a3(ASPECT_CLEAR));
    chk("main_head", a3(main_head), a3(ASPECT_STOP));
    chk("disp_lower", a3(dl), a3(ASPECT_APPROACH));
    chk("disp_upper", a3(du), a3(ASPECT_APPROACH));
    $display("test diverging done");
  endtask

  task automatic t_occ;
    for (int i = 0; i < 3; i++) begin
      drive(ROUTE_DIV, i != 0, i != 1, i != 2, 3'h7, 3'h0);
      chk("trunk_ad", {2'h0, trunk_out.ad}, 3'h0);
      chk("trunk_appr", {2'h0, trunk_out.approach_out_n}, 3'h0);
      chk("main_head", a3(main_head), a3(ASPECT_STOP));
      chk("head_lower", a3(head_lower),
          a3(i == 2 ? ASPECT_STOP : ASPECT_CLEAR));
    end
    $display("test occupancy done");
  endtask

  task automatic t_ad_in;
    drive(ROUTE_DIV, 1'h1, 1'h1, 1'h1, 3'h7, 3'h5);
    chk("ad_seen", {1'b0, ad_seen_trunk, ad_seen_branch}, 3'h3);
    chk("branch_ad", {1'b0, main_out.ad, div_out.ad}, 3'h0);
    drive(ROUTE_MAIN, 1'h1, 1'h1, 1'h1, 3'h7, 3'h5);
    chk("ad_seen", {1'b0, ad_seen_trunk, ad_seen_branch}, 3'h2);
    chk("trunk_ad", {2'h0, trunk_out.ad}, 3'h0);
    $display("test ad input done");
  endtask

  task automatic t_ce;
    drive(ROUTE_MAIN, 1'h1, 1'h1, 1'h1, 3'h7, 3'h0);
    @(posedge clk);
    turnout_div <= ROUTE_DIV;
    repeat (2) @(posedge clk);
    #1;
    chk("head_upper", a3(head_upper), a3(ASPECT_CLEAR));
    @(posedge clk);
    #1;
    chk("head_upper", a3(head_upper), a3(ASPECT_STOP));
    // turnout moves on the same edge that freezes: not captured until ce returns
    @(posedge clk);
    ce <= 1'b0;
    turnout_div <= ROUTE_MAIN;
    repeat (6) @(posedge clk);
    #1;
    chk("head_upper", a3(head_upper), a3(ASPECT_STOP));
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("head_upper", a3(head_upper), a3(ASPECT_STOP));
    @(posedge clk);
    #1;
    chk("head_upper", a3(head_upper), a3(ASPECT_CLEAR));
    $display("test enable done");
  endtask

  initial begin
    t_reset();
    t_main();
    t_div();
    t_occ();
    t_ad_in();
    t_ce();
    t_reset();
    end_of_test();
  end

  // whole run is about 60 cycles; allow far more
  initial begin
    #20000;
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
